// ===== core/wdhr_consts.svh
/*
  Constants for the watchdog, halt and reset-cause block: register offset,
  field positions, reset values and timing counts.
  Assumes inclusion by every design module that needs it.
*/
`ifndef WDHR_CONSTS_SVH
`define WDHR_CONSTS_SVH

`define WDHR_ADDR_PRESCALE   8'h09
`define WDHR_PRESCALE_RESET  8'h07
`define WDHR_PS_LSB          0
`define WDHR_PS_MSB          2
`define WDHR_BASE_STAGES     8
`define WDHR_PS_STAGES       7
`define WDHR_INSTR_DIV       4
`define WDHR_STARTUP_CYCLES  1024
`define WDHR_STAT_TO_BIT     5
`define WDHR_STAT_PDF_BIT    4

`endif

// ===== core/wdhr_pkg.sv
/*
  Types for the watchdog, halt and reset-cause block.
  Assumes the constants header sits beside it.
*/
package wdhr_pkg;
  // Core run state, one-hot
  typedef enum logic [2:0]
  {
    WDHR_RUN   = 3'b001,
    WDHR_HALT  = 3'b010,
    WDHR_START = 3'b100
  } wdhr_state_e;
endpackage

// ===== core/wdhr_divider.sv
/*
  Watchdog ripple counter: fixed base stages followed by prescale stages,
  with the overflow tap chosen by the prescale field.
  Assumes a one-cycle count enable and a synchronous clear.
*/
`timescale 1ns/1ns
`include "wdhr_consts.svh"
module wdhr_divider
  import wdhr_pkg::*;
#(
  parameter int BASE = `WDHR_BASE_STAGES,
  parameter int PS   = `WDHR_PS_STAGES
)
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic [2:0] sel,
  output logic            ovf
);
  localparam int W = BASE + PS;

  logic [W-1:0] cnt_q;   // Base plus prescale chain
  logic [W-1:0] limit;   // Terminal count for the chosen ratio

  // Overflow when the chosen tap carries out: 256 * 2^sel ticks
  always_comb
  begin
    limit = W'((32'd1 << (BASE + 32'(sel))) - 32'd1);
  end

  assign ovf = tick && !clr && (cnt_q == limit);

  // Counter; clear has priority, restart from zero after overflow
  always_ff @(posedge mclk)
  begin
    if (reset || clr)
      cnt_q <= '0;
    else if (ovf)
      cnt_q <= '0;
    else if (tick)
      cnt_q <= cnt_q + W'(1);
  end

  // A tap change may skip past the limit; wrapping still bounds it
  property p_ovf_tick;
    @(posedge mclk) disable iff (reset)
    ovf |-> tick;
  endproperty
  a_ovf_tick : assert property (p_ovf_tick) else $error("overflow without tick");
endmodule // wdhr_divider

// ===== core/wdhr_ctrl.sv
/*
  Watchdog, halt entry, wake-up and reset-cause control.
  Assumes core strobes are one-cycle pulses on mclk and that the RC tick
  is already a one-cycle enable synchronous to mclk.
*/
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "wdhr_consts.svh"
module wdhr_ctrl
  import wdhr_pkg::*;
#(
  parameter bit       WDT_ENABLE   = 1'b1,  // Build option: watchdog present
  parameter bit       WDT_SRC_RC   = 1'b1,  // Build option: RC source
  parameter bit       DOUBLE_CLEAR = 1'b0,  // Build option: two-step clear
  parameter bit       XTAL_OSC     = 1'b1,  // Build option: crystal clock
  parameter bit [7:0] WAKE_MASK_A  = 8'hFF, // Wake-enabled port A bits
  parameter bit [3:0] WAKE_MASK_C  = 4'hF,  // Wake-enabled port C bits
  parameter int       STARTUP      = `WDHR_STARTUP_CYCLES
)
(
  input  wire logic       mclk,
  input  wire logic       reset,          // Power-up reset
  input  wire logic       reset_pin_n,    // External reset pin
  input  wire logic       rc_tick,        // Watchdog RC oscillator pulse
  input  wire logic       clr_single,     // watchdog_clear_single executed
  input  wire logic       clr_first,      // watchdog_clear_first executed
  input  wire logic       clr_second,     // watchdog_clear_second executed
  input  wire logic       halt_exec,      // Halt instruction executed
  input  wire logic       ext_int,        // External interrupt request
  input  wire logic       int_enabled,    // Interrupt enabled
  input  wire logic       stack_full,     // Stack full
  input  wire logic [7:0] port_a,         // Port A pins
  input  wire logic [3:0] port_c,         // Port C pins 0..3
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            chip_reset,     // Full reset pulse
  output logic            warm_reset,     // PC and SP clear pulse
  output logic            take_interrupt, // Vector on interrupt wake
  output logic            resume,         // Continue after halt
  output logic            halted,         // System clock stopped
  output logic            startup_busy,   // Start-up delay running
  output logic            timeout_flag,
  output logic            powerdown_flag
);
  localparam int SW = $clog2(STARTUP + 1);

  wdhr_state_e state_q;             // Run state
  logic [7:0]  ctrl_q;              // Prescale control register
  logic [1:0]  idiv_q;              // Instruction clock divider
  logic        first_q;             // First of two clears seen
  logic [7:0]  pa_q;                // Last port A sample
  logic [3:0]  pc_q;                // Last port C sample
  logic [SW-1:0] st_cnt_q;          // Start-up delay count
  logic        sw_clear;            // Clear sequence complete
  logic        halt_clr;            // Halt clears watchdog, RC source only
  logic        wd_clr;              // Any watchdog clear
  logic        tick;                // Watchdog count enable
  logic        ovf;                 // Raw overflow
  logic        wd_ovf;              // Effective overflow
  logic        pin_fall;            // Wake-capable falling edge
  logic        wake;                // Any wake from halt
  logic        pin_rst;             // Reset pin active

  assign pin_rst = !reset_pin_n;

  // Instruction clock: system clock divided by four
  always_ff @(posedge mclk)
  begin
    if (reset)
      idiv_q <= 2'h0;
    else
      idiv_q <= idiv_q + 2'h1;
  end

  // Source is fixed at build; the instruction clock dies in halt
  always_comb
  begin
    if (!WDT_ENABLE)
      tick = 1'b0;
    else if (WDT_SRC_RC)
      tick = rc_tick;
    else
      tick = (idiv_q == 2'h3) && (state_q != WDHR_HALT);
  end

  // Two-step clear remembers the first instruction
  always_ff @(posedge mclk)
  begin
    if (reset || pin_rst)
      first_q <= 1'b0;
    else if (sw_clear)
      first_q <= 1'b0;
    else if (DOUBLE_CLEAR && clr_first)
      first_q <= 1'b1;
  end

  // Clear sequence per option; a disabled watchdog ignores it
  always_comb
  begin
    if (!WDT_ENABLE)
      sw_clear = 1'b0;
    else if (DOUBLE_CLEAR)
      sw_clear = (clr_second && (first_q || clr_first));
    else
      sw_clear = clr_single;
  end

  assign halt_clr = halt_exec && (state_q == WDHR_RUN) && WDT_SRC_RC;
  assign wd_clr   = pin_rst || sw_clear || halt_clr;

  wdhr_divider #(
    .BASE (`WDHR_BASE_STAGES),
    .PS   (`WDHR_PS_STAGES)
  ) u_div (
    .mclk  (mclk),
    .reset (reset),
    .clr   (wd_clr),
    .tick  (tick),
    .sel   (ctrl_q[`WDHR_PS_MSB:`WDHR_PS_LSB]),
    .ovf   (ovf)
  );

  assign wd_ovf = ovf && WDT_ENABLE;

  // Prescale register; upper bits are free software storage
  always_ff @(posedge mclk)
  begin
    if (reset || pin_rst || (wd_ovf && state_q == WDHR_RUN))
      ctrl_q <= `WDHR_PRESCALE_RESET;
    else if (wr && addr == `WDHR_ADDR_PRESCALE)
      ctrl_q <= wdata;
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (rd && addr == `WDHR_ADDR_PRESCALE)
      rdata <= ctrl_q;
    else
      rdata <= 8'h00;
  end

  // Port samples for falling-edge wake detection
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pa_q <= 8'hFF;
      pc_q <= 4'hF;
    end
    else
    begin
      pa_q <= port_a;
      pc_q <= port_c;
    end
  end

  assign pin_fall = |(pa_q & ~port_a & WAKE_MASK_A) ||
                    |(pc_q & ~port_c & WAKE_MASK_C);
  assign wake = (state_q == WDHR_HALT) && (ext_int || pin_fall);

  // Run state machine; reset pin and overflow also leave halt
  always_ff @(posedge mclk)
  begin
    if (reset)
      state_q <= WDHR_START;
    else if (pin_rst)
      state_q <= WDHR_RUN;
    else
    begin
      unique case (state_q)
        WDHR_RUN:
          if (halt_exec)
            state_q <= WDHR_HALT;
        WDHR_HALT:
          if (wake || wd_ovf)
            state_q <= XTAL_OSC ? WDHR_START : WDHR_RUN;
        WDHR_START:
          if (st_cnt_q == SW'(STARTUP - 1))
            state_q <= WDHR_RUN;
        default:
          state_q <= WDHR_RUN;
      endcase
    end
  end

  // Start-up delay counter
  always_ff @(posedge mclk)
  begin
    if (reset || state_q != WDHR_START)
      st_cnt_q <= '0;
    else
      st_cnt_q <= st_cnt_q + SW'(1);
  end

  // Timeout flag: hardware events only
  always_ff @(posedge mclk)
  begin
    if (reset)
      timeout_flag <= 1'b0;
    else if (wd_ovf)
      timeout_flag <= 1'b1;
    else if (sw_clear || (halt_exec && state_q == WDHR_RUN))
      timeout_flag <= 1'b0;
  end

  // Power-down flag: hardware events only
  always_ff @(posedge mclk)
  begin
    if (reset)
      powerdown_flag <= 1'b0;
    else if (halt_exec && state_q == WDHR_RUN)
      powerdown_flag <= 1'b1;
    else if (sw_clear)
      powerdown_flag <= 1'b0;
  end

  // Reset and resume pulses
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      chip_reset     <= 1'b1;
      warm_reset     <= 1'b0;
      take_interrupt <= 1'b0;
      resume         <= 1'b0;
    end
    else
    begin
      chip_reset     <= pin_rst || (wd_ovf && state_q == WDHR_RUN);
      warm_reset     <= wd_ovf && state_q == WDHR_HALT;
      take_interrupt <= wake && !wd_ovf && ext_int && int_enabled && !stack_full;
      resume         <= wake && !wd_ovf && !(ext_int && int_enabled && !stack_full);
    end
  end

  assign halted       = (state_q == WDHR_HALT);
  assign startup_busy = (state_q == WDHR_START);

  // Halt entry without overflow sets the power-down flag and drops the timeout flag
  property p_halt_flags;
    @(posedge mclk) disable iff (reset || pin_rst)
    (halt_exec && state_q == WDHR_RUN && !wd_ovf) |=> (powerdown_flag && !timeout_flag);
  endproperty
  a_halt_flags : assert property (p_halt_flags) else $error("halt flags wrong");
  // A halt instruction while running stops the system clock unless the reset pin is active
  property p_halt_entry;
    @(posedge mclk) disable iff (reset || pin_rst)
    (halt_exec && state_q == WDHR_RUN) |=> halted;
  endproperty
  a_halt_entry : assert property (p_halt_entry) else $error("halt not entered");
  property p_run_ovf;
    @(posedge mclk) disable iff (reset || pin_rst)
    (wd_ovf && state_q == WDHR_RUN) |=> (chip_reset && timeout_flag && !warm_reset);
  endproperty
  a_run_ovf : assert property (p_run_ovf) else $error("run overflow");
  property p_halt_ovf;
    @(posedge mclk) disable iff (reset || pin_rst)
    (wd_ovf && state_q == WDHR_HALT) |=> (warm_reset && !chip_reset);
  endproperty
  a_halt_ovf : assert property (p_halt_ovf) else $error("halt overflow");
  property p_startup;
    @(posedge mclk) disable iff (reset || pin_rst)
    $rose(startup_busy) |-> startup_busy [*8];
  endproperty
  a_startup : assert property (p_startup) else $error("short start-up");
  property p_pd_clear;
    @(posedge mclk) disable iff (reset)
    (sw_clear && !(halt_exec && state_q == WDHR_RUN)) |=> !powerdown_flag;
  endproperty
  a_pd_clear : assert property (p_pd_clear) else $error("clear kept flag");
  property p_instr_halt;
    @(posedge mclk) disable iff (reset)
    (!WDT_SRC_RC && halted) |-> !tick;
  endproperty
  a_instr_halt : assert property (p_instr_halt) else $error("tick in halt");
  property p_disabled;
    @(posedge mclk) disable iff (reset)
    !WDT_ENABLE |-> (!wd_ovf && !sw_clear);
  endproperty
  a_disabled : assert property (p_disabled) else $error("disabled acts");
  property p_wake;
    @(posedge mclk) disable iff (reset || pin_rst)
    (halted && pin_fall && !wd_ovf) |=> !halted;
  endproperty
  a_wake : assert property (p_wake) else $error("no wake");
endmodule // wdhr_ctrl

// ===== dv/test_watchdog_halt_reset_ctrl.sv
/*
  Self-checking bench for the watchdog, halt and reset-cause control.
  Assumes the core package and modules are compiled first.
*/
`timescale 1ns/1ns
module test_watchdog_halt_reset_ctrl;
  import wdhr_pkg::*;
  localparam int SU = 16;        // Shortened start-up delay
  logic       mclk, reset;       // Clock and power-up reset
  logic       reset_pin_n;       // External reset pin
  logic       rc_tick;           // Watchdog oscillator enable
  logic       clr_single, clr_first, clr_second, halt_exec;
  logic       ext_int, int_enabled, stack_full;
  logic [7:0] port_a, addr, wdata, rdata;
  logic [3:0] port_c;
  logic       wr, rd, chip_reset, warm_reset, take_interrupt, resume;
  logic       halted, startup_busy, timeout_flag, powerdown_flag;
  int         bad_count, n_tests; // Mismatches and comparisons
  int         n_chip, n_warm, n_int, n_res; // Result pulse tallies

  wdhr_ctrl #(.STARTUP(SU)) dut_u
  (
    .mclk, .reset, .reset_pin_n, .rc_tick, .clr_single, .clr_first,
    .clr_second, .halt_exec, .ext_int, .int_enabled, .stack_full, .port_a,
    .port_c, .addr, .wdata, .wr, .rd, .rdata, .chip_reset, .warm_reset,
    .take_interrupt, .resume, .halted, .startup_busy, .timeout_flag,
    .powerdown_flag
  );

  // 25 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Tally result pulses; scenarios compare deltas, so reset-time highs are harmless
  always @(posedge mclk)
  begin
    n_chip <= n_chip + int'(chip_reset === 1'b1);
    n_warm <= n_warm + int'(warm_reset === 1'b1);
    n_int  <= n_int + int'(take_interrupt === 1'b1);
    n_res  <= n_res + int'(resume === 1'b1);
  end

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Cycles until a tally moves, or lim if it never does
  task automatic wait_inc(ref int c, input int lim, output int k);
    int c0;
    c0 = c;
    for (k = 0; k < lim && c == c0; k++)
      @(posedge mclk);
  endtask

  // One-cycle instruction strobe: {halt, second, first, single}
  task automatic inst(input logic [3:0] m);
    {halt_exec, clr_second, clr_first, clr_single} <= m;
    tick(1);
    {halt_exec, clr_second, clr_first, clr_single} <= 4'h0;
    tick(2);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    tick(1);
    wr    <= 1'b0;
  endtask

  // Read data is taken only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    tick(1);
    rd   <= 1'b0;
    #1 d = rdata;
    tick(1);
  endtask

  // Pin reset also leaves any halt without a start-up delay
  task automatic pin_rst();
    reset_pin_n <= 1'b0;
    tick(2);
    reset_pin_n <= 1'b1;
    tick(2);
  endtask

  task automatic t_power_up();
    int k;
    logic [7:0] d;
    chk("por_chip", 1, chip_reset);
    chk("por_flags", 2'b00, {timeout_flag, powerdown_flag});
    reset <= 1'b0;
    tick(2);
    for (k = 0; k < 40 && startup_busy === 1'b1; k++) tick(1);
    chk("sst_len", 1, k >= SU - 3 && k <= SU + 1);
    reg_rd(8'h09, d);
    chk("ps_reset", 8'h07, d);
    $display("test power_up done");
  endtask

  task automatic t_regs();
    logic [7:0] d;
    reg_wr(8'hA5, 8'h3C);
    reg_wr(8'h09, 8'hF8);
    reg_rd(8'h09, d);
    chk("ps_store", 8'hF8, d);
    reg_rd(8'hA5, d);
    chk("unmapped", 8'h00, d);
    $display("test regs done");
  endtask

  task automatic t_run_ovf();
    int k;
    logic [7:0] d;
    for (int s = 0; s < 2; s++)
    begin
      pin_rst();
      chk("pin_keeps", {1'b0, s[0]}, timeout_flag);
      reg_wr(8'h09, 8'(s));
      rc_tick <= 1'b1;
      wait_inc(n_chip, 700, k);
      rc_tick <= 1'b0;
      chk("ovf_len", 1, k >= (256 << s) - 2 && k <= (256 << s) + 4);
      tick(SU + 4);
      chk("run_to", 1, timeout_flag);
      reg_rd(8'h09, d);
      chk("ps_reload", 8'h07, d);
    end
    $display("test run_ovf done");
  endtask

  task automatic t_clear();
    int c0;
    pin_rst();
    reg_wr(8'h09, 8'h00);
    c0 = n_chip;
    rc_tick <= 1'b1;
    repeat (3)
    begin
      tick(200);
      inst(4'h1);
    end
    tick(100);
    rc_tick <= 1'b0;
    chk("clr_holds", c0, n_chip);
    $display("test clear done");
  endtask

  task automatic t_halt_pin();
    int k;
    pin_rst();
    inst(4'h8);
    chk("halted", 1, halted);
    chk("halt_flags", 2'b01, {timeout_flag, powerdown_flag});
    port_a <= 8'hF7;
    wait_inc(n_res, 8, k);
    chk("pin_wake", 1, k < 8);
    chk("xtal_wait", 1, startup_busy);
    tick(SU + 2);
    chk("sst_done", 0, startup_busy);
    chk("pin_flags", 2'b01, {timeout_flag, powerdown_flag});
    port_a <= 8'hFF;
    inst(4'h1);
    chk("pd_clr", 0, powerdown_flag);
    $display("test halt_pin done");
  endtask

  task automatic t_halt_wdt();
    int k;
    int c0;
    logic [7:0] d;
    pin_rst();
    reg_wr(8'h09, 8'hF0);
    c0 = n_chip;
    rc_tick <= 1'b1;
    tick(200);
    inst(4'h8);
    wait_inc(n_warm, 320, k);
    rc_tick <= 1'b0;
    chk("warm_len", 1, k > 248 && k < 262);
    chk("no_chip", c0, n_chip);
    tick(SU + 4);
    chk("wdt_flags", 2'b11, {timeout_flag, powerdown_flag});
    reg_rd(8'h09, d);
    chk("ps_kept", 8'hF0, d);
    $display("test halt_wdt done");
  endtask

  task automatic t_halt_int();
    int a;
    int r;
    for (int f = 0; f < 2; f++)
    begin
      pin_rst();
      stack_full <= f[0];
      inst(4'h8);
      a = n_int;
      r = n_res;
      ext_int <= 1'b1;
      tick(1);
      ext_int <= 1'b0;
      tick(SU + 6);
      chk("int_vec", f == 0, n_int - a);
      chk("int_cont", f == 1, n_res - r);
    end
    $display("test halt_int done");
  endtask

  // Watchdog on the run; the scenarios need well under 10,000 cycles
  initial
  begin
    #(40 * 20000);
    bad_count++;
    wrap_up();
  end

  initial
  begin
    {reset, reset_pin_n, int_enabled} = 3'b111;
    {rc_tick, clr_single, clr_first, clr_second, halt_exec} = 5'h00;
    {ext_int, stack_full, wr, rd} = 4'h0;
    {port_a, port_c, addr, wdata} = {8'hFF, 4'hF, 8'h00, 8'h00};
    {bad_count, n_tests, n_chip, n_warm, n_int, n_res} = '0;
    tick(5);
    t_power_up();
    t_regs();
    t_run_ovf();
    t_clear();
    t_halt_pin();
    t_halt_wdt();
    t_halt_int();
    wrap_up();
  end
endmodule // test_watchdog_halt_reset_ctrl
